// [include/meter_pkg.sv]
package meter_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] STATUS_OFS  = 8'h04;
  localparam logic [7:0] IRQ_ST_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MSK_OFS = 8'h0C;
  localparam logic [7:0] DECODE_OFS  = 8'h10;
  localparam logic [7:0] PRIM_OFS    = 8'h14;
  localparam logic [7:0] AUXA_OFS    = 8'h18;
  localparam logic [7:0] AUXB_OFS    = 8'h1C;
  localparam logic [7:0] SIGNED_OFS  = 8'h20;
  // Control field positions
  localparam int FUNC_LSB  = 0;
  localparam int AC_BIT    = 4;
  localparam int RANGE_LSB = 5;
  localparam int HZ_LSB    = 8;
  localparam int GAIN_BIT  = 11;
  localparam int BEEP_BIT  = 12;
  localparam int CTRL_W    = 13;
  localparam logic [12:0] CTRL_RST = 13'h0000;
  // Interrupt status bits
  localparam int EV_ALARM  = 0;
  localparam int EV_LOWRES = 1;
  localparam int EV_DATA   = 2;
  localparam int EV_W      = 3;
  localparam logic [2:0] MASK_RST = 3'h0;
  // Widths
  localparam int PRIM_W = 13;
  localparam int AUX_W  = 20;
  // Function codes
  typedef enum logic [3:0] {
    FN_VOLT  = 4'b0000,
    FN_CURR  = 4'b0001,
    FN_RES   = 4'b0010,
    FN_CONT  = 4'b0011,
    FN_DIODE = 4'b0100
  } func_e;
  // Voltage ranges
  localparam logic [2:0] VR_6V     = 3'h0;
  localparam logic [2:0] VR_60V    = 3'h1;
  localparam logic [2:0] VR_600V   = 3'h2;
  localparam logic [2:0] VR_1000V  = 3'h3;
  localparam logic [2:0] VR_600MV  = 3'h4;
  // Resistance ranges
  localparam logic [2:0] RR_600    = 3'h1;
  localparam logic [2:0] RR_60M    = 3'h6;
  // Frequency ranges
  localparam logic [2:0] HZ_600    = 3'h1;
  localparam logic [2:0] HZ_60K    = 3'h3;
endpackage

// [core/meter_mode_range_select.sv]
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
// Function
// - Function 0000 selects voltage; AC bit adds AC reading with frequency.
// - Primary is 13 bits plus sign; aux counts 20 bits, AC-Hz only.
// - Voltage range codes 000 to 100 select the divider ratio.
// - Frequency range 001..011 valid in AC-Hz modes; 000 is invalid.
// - Voltage modes raise alarm on high crest factor input.
// - Function 0001 selects current; AC bit adds frequency measurement.
// - Current range 000: gain select 1 gives 30mV, 0 gives 300mV scale.
// - Function 0010 is resistance; primary only, sign meaningless.
// - Resistance range codes 001..110 select 600 ohm to 60M; 000 invalid.
// - Function 0011 is continuity on lowest resistance setup, primary only.
// - Continuity drives low-resistance output low below minus 7 mV.
// - Auto beep with low resistance drives buzzer and raises alarm.
// - Function 0100 is diode check on 6V voltage setup, sign valid.
// - Diode check drives low-resistance output low below 7 mV.
// - Sign set presents reading as minus the primary magnitude in voltage, current and diode modes.
module meter_mode_range_select
  import meter_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst,
  input  wire logic                       clkEn,
  input  wire logic [7:0]                 address,
  input  wire logic                       read,
  input  wire logic                       write,
  input  wire logic [31:0]                writedata,
  input  wire logic [3:0]                 byteenable,
  output logic      [31:0]                readdata,
  output logic                            waitrequest,
  input  wire logic [meter_pkg::PRIM_W-1:0] primaryIn,
  input  wire logic                       signIn,
  input  wire logic [meter_pkg::AUX_W-1:0] auxAIn,
  input  wire logic [meter_pkg::AUX_W-1:0] auxBIn,
  input  wire logic                       resultValid,
  input  wire logic                       highCrestPin,
  input  wire logic                       senseBelowNeg7Pin,
  input  wire logic                       senseBelowPos7Pin,
  output logic                            lowResDetectN,
  output logic                            buzzerDrive,
  output logic                            alarmFlag,
  output logic [2:0]                      dividerSel,
  output logic                            currentHighGain,
  output logic                            freqEnable,
  output logic                            irq
);
  import meter_pkg::*;

  // Control word as the controller writes it:
  //   [3:0] function code, [4] AC with frequency
  //   [7:5] range code, [10:8] frequency range
  //   [11] gain select, [12] automatic beep
  // Upper bits are not stored and read back zero
  // Reset leaves DC voltage on the 6V divider
  // Safe start: lowest divider ratio but one, no buzzer

  // Byte-lane merge, used by the control and mask registers
  function automatic logic [31:0] laneMerge(input logic [31:0] oldV,
                                            input logic [31:0] newV,
                                            input logic [3:0]  be);
    logic [31:0] r;
    r = oldV;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = newV[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Inclusive code window check, shared by the resistance and frequency range decoders
  function automatic logic inRange(input logic [2:0] code,
                                   input logic [2:0] lo,
                                   input logic [2:0] hi);
    return (code >= lo) && (code <= hi);
  endfunction

  // Two-flop synchronisers for the comparator pins
  // Comparators toggle with no regard to our clock
  // Only the second flop is read, never the first
  logic [2:0] pinMeta;
  logic [2:0] pinSync;
  always_ff @(posedge clock) begin
    if (rst) begin
      pinMeta <= 3'h0;
      pinSync <= 3'h0;
    end else if (clkEn) begin
      pinMeta <= {senseBelowPos7Pin, senseBelowNeg7Pin, highCrestPin};
      pinSync <= pinMeta;
    end
  end
  wire hcfSync    = pinSync[0];
  wire belowNeg7  = pinSync[1];
  wire belowPos7  = pinSync[2];
  // Two cycles of latency before decode
  // Trade-off: slower detect for no metastable decode
  // Pin outputs follow one edge later still

  // Held control word
  logic [CTRL_W-1:0] ctrl;
  logic [EV_W-1:0]   irqStatus;
  logic [EV_W-1:0]   irqMask;

  // Field decode of the control word
  wire [3:0] funcCode   = ctrl[FUNC_LSB +: 4];
  wire       acSel      = ctrl[AC_BIT];
  wire [2:0] rangeSel   = ctrl[RANGE_LSB +: 3];
  wire [2:0] hzRange    = ctrl[HZ_LSB +: 3];
  wire       gainSelect = ctrl[GAIN_BIT];
  wire       autoBeep   = ctrl[BEEP_BIT];

  wire isVolt  = (funcCode == FN_VOLT);
  wire isCurr  = (funcCode == FN_CURR);
  wire isRes   = (funcCode == FN_RES);
  wire isCont  = (funcCode == FN_CONT);
  wire isDiode = (funcCode == FN_DIODE);
  // Codes above 0100 match no mode: pins idle, except dividerSel, which follows the range code
  // Kept as a flag so status can report a bad function write
  wire modeKnown = isVolt | isCurr | isRes | isCont | isDiode;

  // AC with frequency in voltage or current
  wire acHzMode = (isVolt | isCurr) & acSel;

  wire voltRangeOk = (rangeSel <= VR_600MV);
  wire resRangeOk  = inRange(rangeSel, RR_600, RR_60M);
  wire currRangeOk = (rangeSel == 3'h0);
  wire hzRangeOk   = inRange(hzRange, HZ_600, HZ_60K);

  // Continuity and diode force their own setup
  // Any range code is then acceptable
  wire rangeOk = (isVolt & voltRangeOk) |
                 (isCurr & currRangeOk) |
                 (isRes & resRangeOk) |
                 isCont |
                 isDiode;

  // continuity on lowest ohm range; diode on 6V range
  wire [2:0] next_dividerSel = isCont  ? RR_600 :
                               isDiode ? VR_6V  : rangeSel;

  // Comparators already encode the two thresholds
  // Outside these modes the pins are ignored
  // continuity threshold; diode threshold
  wire lowResNow = (isCont & belowNeg7) | (isDiode & belowPos7);

  // Alarm is a level, not latched; the event bit keeps history
  // Controller must poll or unmask the alarm event
  // crest factor alarm; beep alarm
  wire beepNow  = autoBeep & lowResNow;
  wire alarmNow = (isVolt & hcfSync) | beepNow;

  // Gain select ignored outside current mode
  // Avoids a stray high gain path in other modes
  // high gain only on current range 000
  wire next_highGain = isCurr & currRangeOk & gainSelect;

  // Converter words hold between result strobes
  // Captured converter words
  logic [PRIM_W-1:0] primary;
  logic              signFlag;
  logic [AUX_W-1:0]  auxA;
  logic [AUX_W-1:0]  auxB;

  // sign dropped where it carries no meaning
  wire signValid = isVolt | isCurr | isDiode;
  // aux words returned only in AC-Hz modes
  wire auxAllowed = acHzMode;

  // Magnitude is zero-extended before negation
  // Two's complement result, full 32 bits
  // signed view of the primary reading
  wire [31:0] magExt    = {{(32-PRIM_W){1'b0}}, primary};
  wire [31:0] signedVal = signFlag ? (32'h0000_0000 - magExt) : magExt;

  // Decode word layout:
  //   [2:0] divider, [3] volt, [4] curr, [5] res
  //   [6] cont, [7] diode, [8] frequency enable
  //   [9] high gain, [10] aux words allowed
  // Read and write together is refused, no answer
  // Writes land only at the accepting edge
  // Register decode
  wire reqRead  = read & ~write;
  wire reqWrite = write & ~read;
  wire acceptEdge = (reqRead | reqWrite) & ~waitrequest;
  wire hitCtrl  = (address == CTRL_OFS);
  wire hitIst   = (address == IRQ_ST_OFS);
  wire hitImsk  = (address == IRQ_MSK_OFS);
  wire doWrite  = clkEn & acceptEdge & reqWrite;

  wire [31:0] ctrlMerged = laneMerge({{(32-CTRL_W){1'b0}}, ctrl}, writedata, byteenable);
  wire [31:0] mskMerged  = laneMerge({{(32-EV_W){1'b0}}, irqMask}, writedata, byteenable);
  wire [EV_W-1:0] w1cBits = (doWrite & hitIst & byteenable[0]) ?
                            writedata[EV_W-1:0] : {EV_W{1'b0}};

  // Interrupt events: rising alarm, rising low-res, new reading
  logic alarmPrev;
  logic lowResPrev;
  wire [EV_W-1:0] events = {resultValid & modeKnown,
                            lowResNow & ~lowResPrev,
                            alarmNow & ~alarmPrev};

  // Status word layout:
  //   [0] alarm now, [1] low resistance now
  //   [2] sign in modes where it means something
  //   [3] AC with frequency, [4] function known
  //   [5] range valid, [6] frequency range valid
  // Levels, not sticky; events live in the interrupt status
  // Unmapped offsets read zero, writes to them are dropped
  // Read mux; disallowed words read zero
  wire [31:0] statusWord = {25'h0, hzRangeOk & acHzMode, rangeOk, modeKnown,
                            acHzMode, signFlag & signValid, lowResNow, alarmNow};
  wire [31:0] decodeWord = {21'h0, auxAllowed, next_highGain, freqEnable,
                            isDiode, isCont, isRes, isCurr, isVolt, next_dividerSel};
  wire [31:0] primWord   = {15'h0, signFlag & signValid, 3'h0, primary};
  logic [31:0] rdMux;
  always_comb begin
    case (address)
      CTRL_OFS:    rdMux = {{(32-CTRL_W){1'b0}}, ctrl};
      STATUS_OFS:  rdMux = statusWord;
      IRQ_ST_OFS:  rdMux = {{(32-EV_W){1'b0}}, irqStatus};
      IRQ_MSK_OFS: rdMux = {{(32-EV_W){1'b0}}, irqMask};
      DECODE_OFS:  rdMux = decodeWord;
      PRIM_OFS:    rdMux = primWord;
      AUXA_OFS:    rdMux = auxAllowed ? {12'h0, auxA} : 32'h0000_0000;
      AUXB_OFS:    rdMux = auxAllowed ? {12'h0, auxB} : 32'h0000_0000;
      SIGNED_OFS:  rdMux = signValid ? signedVal : magExt;
      default:     rdMux = 32'h0000_0000;
    endcase
  end

  // Fixed latency: every request waits exactly one cycle
  // Registered answer keeps the read mux off the bus path
  // After an accept, waitrequest rises and stays high until the next request has waited one cycle
  // So back-to-back accesses cost two cycles each
  // Clock enable low stalls the handshake as well
  // Read data stands until the next answer; a write answer loads zero
  // Bus handshake: answer one cycle after the request appears
  always_ff @(posedge clock) begin
    if (rst) begin
      waitrequest <= 1'b1;
      readdata    <= 32'h0000_0000;
    end else if (clkEn) begin
      if (acceptEdge) begin
        waitrequest <= 1'b1;
      end else if (reqRead | reqWrite) begin
        waitrequest <= 1'b0;
        readdata    <= reqRead ? rdMux : 32'h0000_0000;
      end
    end
  end

  // Byte lanes merge into the old value
  // Partial writes leave the other fields alone
  // settings held until the next write
  always_ff @(posedge clock) begin
    if (rst) begin
      ctrl    <= CTRL_RST;
      irqMask <= MASK_RST;
    end else if (doWrite) begin
      if (hitCtrl) begin
        ctrl <= ctrlMerged[CTRL_W-1:0];
      end
      if (hitImsk) begin
        irqMask <= mskMerged[EV_W-1:0];
      end
    end
  end

  // Edge detectors start at the idle level
  // No false event after reset
  // Sticky events; a new event beats a same-cycle clear
  always_ff @(posedge clock) begin
    if (rst) begin
      irqStatus  <= {EV_W{1'b0}};
      alarmPrev  <= 1'b0;
      lowResPrev <= 1'b0;
    end else if (clkEn) begin
      irqStatus  <= (irqStatus & ~w1cBits) | events;
      alarmPrev  <= alarmNow;
      lowResPrev <= lowResNow;
    end
  end

  // Aux words are zeroed when not allowed
  // Stale frequency counts cannot leak into DC modes
  // capture converter words on each result strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      primary  <= '0;
      signFlag <= 1'b0;
      auxA     <= '0;
      auxB     <= '0;
    end else if (clkEn && resultValid) begin
      primary  <= primaryIn;
      signFlag <= signIn;
      auxA     <= auxAllowed ? auxAIn : '0;
      auxB     <= auxAllowed ? auxBIn : '0;
    end
  end

  // Registered pin outputs; one cycle behind decode
  always_ff @(posedge clock) begin
    if (rst) begin
      lowResDetectN   <= 1'b1;
      buzzerDrive     <= 1'b0;
      alarmFlag       <= 1'b0;
      dividerSel      <= 3'h0;
      currentHighGain <= 1'b0;
      freqEnable      <= 1'b0;
      irq             <= 1'b0;
    end else if (clkEn) begin
      lowResDetectN   <= ~lowResNow;
      buzzerDrive     <= beepNow;
      alarmFlag       <= alarmNow;
      dividerSel      <= next_dividerSel;
      currentHighGain <= next_highGain;
      // frequency counter only with a valid range
      freqEnable      <= acHzMode & hzRangeOk;
      // Look-ahead on the next status value
      // Keeps irq aligned with the status register
      // A same-cycle clear also hides a new event from irq
      irq             <= |((irqStatus | events) & ~w1cBits
                           & irqMask);
    end
  end

endmodule

// [testbench/meter_sva.sv]
`timescale 1ns/1ps
module meter_sva (
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       read,
  input wire logic       write,
  input wire logic       waitrequest,
  input wire logic       highCrestPin,
  input wire logic       senseBelowNeg7Pin,
  input wire logic       senseBelowPos7Pin,
  input wire logic       lowResDetectN,
  input wire logic       buzzerDrive,
  input wire logic       alarmFlag,
  input wire logic [2:0] dividerSel,
  input wire logic       currentHighGain,
  input wire logic       irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // One answer cycle per request, then idle
  bus_answer_a: assert property ((read ^ write) && waitrequest |=> !waitrequest)
    else $error("request not answered");
  bus_stand_a: assert property (!waitrequest |=> waitrequest) else $error("answer too long");
  reset_state_a: assert property (disable iff (1'b0)
    rst |=> waitrequest && lowResDetectN && !irq && !alarmFlag) else $error("bad reset");
  beep_alarm_a: assert property (buzzerDrive |-> alarmFlag && !lowResDetectN)
    else $error("buzzer without cause");
  gain_range_a: assert property (currentHighGain |-> dividerSel == 3'h0)
    else $error("high gain off range");
  // Comparators pass a 2-flop sync, so cause sits 3 edges back
  lowres_cause_a: assert property (!lowResDetectN |->
    $past(senseBelowNeg7Pin, 3) || $past(senseBelowPos7Pin, 3)) else $error("lowres no cause");
  lowres_idle_a: assert property ((!senseBelowNeg7Pin && !senseBelowPos7Pin) [*4]
    |=> lowResDetectN) else $error("lowres stuck");
  alarm_cause_a: assert property (alarmFlag && !buzzerDrive |-> $past(highCrestPin, 3))
    else $error("alarm no cause");
  cover property (buzzerDrive);
  cover property (write && !waitrequest);
  cover property (irq);
  cover property (currentHighGain);
endmodule

// [testbench/meter_front_model.sv]
`timescale 1ns/1ps
module meter_front_model (
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic [12:0] mag,
  input  wire logic        sgn,
  input  wire logic [19:0] aA,
  input  wire logic [19:0] aB,
  input  wire logic [2:0]  pins,
  output logic [12:0]      primaryIn,
  output logic             signIn,
  output logic [19:0]      auxAIn,
  output logic [19:0]      auxBIn,
  output logic             resultValid,
  output logic             highCrestPin,
  output logic             senseBelowNeg7Pin,
  output logic             senseBelowPos7Pin
);
  // Words hold only during the strobe; otherwise inverted garbage
  always_ff @(posedge clock) begin
    resultValid <= go;
    {primaryIn, signIn, auxAIn, auxBIn} <= go ? {mag, sgn, aA, aB}
      : ~{primaryIn, signIn, auxAIn, auxBIn};
  end
  assign {senseBelowPos7Pin, senseBelowNeg7Pin, highCrestPin} = pins;
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  import meter_pkg::*;
  logic clock = 0, rst = 1, read = 0, write = 0, go = 0, sgn = 0, se, clkEn = 1;
  logic [7:0] address = 8'h00;
  logic [31:0] writedata = 32'h0000_0000, readdata, q, d, p;
  logic waitrequest, lowResDetectN, buzzerDrive, alarmFlag, currentHighGain, freqEnable, irq;
  logic [2:0] dividerSel, pins = 3'h0;
  logic [12:0] mag = 13'h0000, c, primaryIn;
  logic resultValid, signIn, highCrestPin, senseBelowNeg7Pin, senseBelowPos7Pin;
  logic [19:0] aA = 20'h0_0000, aB = 20'h0_0000, auxAIn, auxBIn;
  int n_fail = 0, cmp_count = 0, cycles = 0, f;
  meter_mode_range_select DUT (.clock, .rst, .clkEn, .address, .read, .write,
    .writedata, .byteenable(4'hF), .readdata, .waitrequest, .primaryIn, .signIn, .auxAIn,
    .auxBIn, .resultValid, .highCrestPin, .senseBelowNeg7Pin, .senseBelowPos7Pin,
    .lowResDetectN, .buzzerDrive, .alarmFlag, .dividerSel, .currentHighGain, .freqEnable, .irq);
  meter_front_model u_front (.clock, .go, .mag, .sgn, .aA, .aB, .pins, .primaryIn, .signIn,
    .auxAIn, .auxBIn, .resultValid, .highCrestPin, .senseBelowNeg7Pin, .senseBelowPos7Pin);
  always #5 clock = ~clock;
  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      conclude;
    end
  end
  function automatic logic [31:0] fdec(input logic [12:0] c);
    logic [3:0] f;
    logic vc;
    f = c[3:0];
    vc = f == FN_VOLT || f == FN_CURR;
    fdec = 32'h0000_0000;
    fdec[2:0] = f == FN_CONT ? RR_600 : f == FN_DIODE ? VR_6V : c[RANGE_LSB+:3];
    fdec[3+f] = 1'h1;
    fdec[8] = c[AC_BIT] && vc && c[HZ_LSB+:3] >= HZ_600 && c[HZ_LSB+:3] <= HZ_60K;
    fdec[9] = f == FN_CURR && c[RANGE_LSB+:3] == 3'h0 && c[GAIN_BIT];
    fdec[10] = c[AC_BIT] && vc;
  endfunction
  // Expected {alarm, buzzer, lowResN} from mode and comparator levels
  function automatic logic [2:0] fpin(input logic [12:0] c, input logic [2:0] p);
    logic lo;
    lo = (c[3:0] == FN_CONT && p[1]) || (c[3:0] == FN_DIODE && p[2]);
    fpin = {(lo && c[BEEP_BIT]) || (c[3:0] == FN_VOLT && p[0]), lo && c[BEEP_BIT], !lo};
  endfunction
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Master holds the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= wd;
    do @(posedge clock); while (waitrequest !== 1'h0);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 32'h0000_0000);
    chk(q, e);
  endtask
  task automatic pulse;
    @(posedge clock);
    go <= 1'h1;
    @(posedge clock);
    go <= 1'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic conclude;
    $display("compares=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h4dac_1d09));
    repeat (4) @(posedge clock);
    rst <= 1'h0;
    for (int i = 0; i < 20; i++) begin
      f = i % 5;
      c = {1'($urandom), 1'($urandom), 3'($urandom % 4),
        3'(f == 1 ? 0 : f == 2 ? 1 + $urandom % 6 : $urandom % 5), 1'($urandom), 4'(f)};
      if (i < 5) c[RANGE_LSB+:3] = f == 0 ? VR_600MV : f == 2 ? RR_60M : c[RANGE_LSB+:3];
      bus(1'h1, CTRL_OFS, {19'h0_0000, c});
      d = fdec(c);
      rdc(CTRL_OFS, {19'h0_0000, c});
      rdc(DECODE_OFS, d);
      chk({27'h000_0000, freqEnable, currentHighGain, dividerSel}, {27'h0, d[8], d[9], d[2:0]});
      p[12:0] = 13'($urandom % 6000);
      // high gain reading at half scale
      if (d[9]) p[12:0] = p[12:0] >> 1;
      mag <= p[12:0];
      se = 1'($urandom);
      sgn <= se;
      aA <= 20'($urandom);
      aB <= p[12:0] < 60 ? 20'h0_0000 : 20'($urandom);
      se = se && f != FN_RES && f != FN_CONT;
      pulse;
      rdc(STATUS_OFS, {25'h0, d[8], 2'b11, d[10], se, 2'b00});
      rdc(PRIM_OFS, {15'h0000, se, 3'h0, mag});
      rdc(AUXA_OFS, d[10] ? {12'h000, aA} : 32'h0000_0000);
      rdc(AUXB_OFS, d[10] ? {12'h000, aB} : 32'h0000_0000);
      rdc(SIGNED_OFS, se ? -{19'h0_0000, mag} : {19'h0_0000, mag});
    end
    // Frozen clock enable: a strobe during the freeze must not land
    p = {15'h0000, se, 3'h0, mag};
    clkEn <= 1'h0;
    mag <= ~mag;
    pulse;
    clkEn <= 1'h1;
    rdc(PRIM_OFS, p);
    for (int i = 0; i < 12; i++) begin
      f = $urandom % 3;
      c = {1'($urandom), 8'h00, 4'(f == 0 ? 0 : f + 2)};
      bus(1'h1, CTRL_OFS, {19'h0_0000, c});
      pins <= 3'($urandom);
      repeat (6) @(posedge clock);
      chk({29'h0, alarmFlag, buzzerDrive, lowResDetectN}, {29'h0, fpin(c, pins)});
      if (alarmFlag && f == 0) bus(1'h1, CTRL_OFS, {19'h0_0000, c | 13'h0020});
    end
    pins <= 3'h0;
    bus(1'h1, IRQ_MSK_OFS, 32'h0000_0004);
    bus(1'h1, IRQ_ST_OFS, 32'h0000_0007);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0000_0000);
    pulse;
    chk({31'h0, irq}, 32'h0000_0001);
    rdc(IRQ_ST_OFS, 32'h0000_0004);
    bus(1'h1, IRQ_ST_OFS, 32'h0000_0004);
    repeat (2) @(posedge clock);
    chk({31'h0, irq}, 32'h0000_0000);
    bus(1'h1, IRQ_MSK_OFS, 32'h0000_0000);
    pulse;
    chk({31'h0, irq}, 32'h0000_0000);
    rdc(IRQ_MSK_OFS, 32'h0000_0000);
    rdc(8'h24, 32'h0000_0000);
    conclude;
  end
endmodule
bind meter_mode_range_select meter_sva u_sva (.clock(clock), .rst(rst), .read(read),
  .write(write), .waitrequest(waitrequest), .highCrestPin(highCrestPin),
  .senseBelowNeg7Pin(senseBelowNeg7Pin), .senseBelowPos7Pin(senseBelowPos7Pin),
  .lowResDetectN(lowResDetectN), .buzzerDrive(buzzerDrive), .alarmFlag(alarmFlag),
  .dividerSel(dividerSel), .currentHighGain(currentHighGain), .irq(irq));
